// ==== rcc_counter.sv ====
// Purpose: per-channel relay closure counter with periodic nonvolatile flush
// Assumes: command inputs are one-cycle pulses from a remote command parser
// Notes:   nonvolatile store is an external write port with acknowledge
`timescale 1ns/1ns
`include "rcc_regs.svh"
module rcc_counter import rcc_pkg::*; #(
    parameter int unsigned CHANNELS      = 10,
    parameter int unsigned COUNT_W       = 32,
    parameter int unsigned MINUTE_CYCLES = `RCC_MINUTE_CYCLES
) (
    input  wire logic                clock,                      // 25 MHz clock
    input  wire logic                resetn,                     // Async reset, active low
    input  wire logic [CHANNELS-1:0] relay_closed,               // Relay state, 1 = closed
    input  wire logic                cmd_valid,                  // Remote command pulse
    input  wire logic [1:0]          cmd_code,                   // Remote command code
    input  wire logic [3:0]          cmd_slot,                   // Slot digit of channel list
    input  wire logic [7:0]          cmd_first,                  // First channel number
    input  wire logic [7:0]          cmd_last,                   // Last channel, = first if none
    input  wire logic [10:0]         cmd_interval,               // Interval minutes
    input  wire logic                calibration_unlock_request, // Unlock code accepted
    input  wire logic                calibration_lock_request,   // Lock calibration
    input  wire logic                front_key_at_powerup,       // Key held during power-up
    input  wire logic                nv_ack,                     // Nonvolatile write done
    output logic                     resp_valid,                 // Response word pulse
    output logic [COUNT_W-1:0]       resp_data,                  // Count or interval
    output logic                     cmd_refused,                // Command refused pulse
    output logic                     nv_write,                   // Nonvolatile write strobe
    output logic [CHANNELS*COUNT_W-1:0] nv_data,                 // Counts to store
    output logic                     calibration_active          // Calibration unlocked
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic [COUNT_W-1:0]  count [CHANNELS];
    logic [CHANNELS-1:0] relay_prev;
    logic [10:0]         interval;
    logic [10:0]         minutes;
    logic                key_seen;
    logic                first_cycle;
    logic                scan_busy;
    logic [7:0]          scan_ch;
    logic [7:0]          scan_last;
    rcc_state_t          state;
    rcc_state_t          next_state;
    logic                tick;

    wire slot_ok   = (cmd_slot == `RCC_SLOT_DIGIT);
    wire range_ok  = slot_ok && (cmd_first >= 8'h01) && (cmd_last >= cmd_first)
                     && (cmd_last <= 8'(CHANNELS));
    wire is_query  = cmd_valid && (cmd_code == RCC_CMD_QUERY);
    wire is_clear  = cmd_valid && (cmd_code == RCC_CMD_CLEAR);
    wire is_setint = cmd_valid && (cmd_code == RCC_CMD_SET_INT);
    wire is_rdint  = cmd_valid && (cmd_code == RCC_CMD_READ_INT);
    wire int_ok    = (cmd_interval >= `RCC_INTERVAL_MIN)
                     && (cmd_interval <= `RCC_INTERVAL_MAX);
    wire clear_go  = is_clear && range_ok && calibration_active && !scan_busy;
    wire query_go  = is_query && range_ok && !scan_busy;
    wire refuse    = (is_clear && !clear_go) || (is_query && !query_go)
                     || (is_setint && !int_ok);
    wire expired   = tick && (minutes + 11'h001 >= interval);
    // flush only on expiry or query
    wire flush_req = expired || query_go;
    wire scan_idx_ok = scan_busy && (scan_ch != 8'h00);
    wire [7:0] scan_idx = scan_ch - 8'h01;
    wire nv_done   = (state == RCC_WAIT) && nv_ack;

    // ------------------------------------------------------------
    // Closure counting
    // ------------------------------------------------------------
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        wire closure = relay_closed[c] && !relay_prev[c];
        wire cleared = clear_go && (8'(c + 1) >= cmd_first) && (8'(c + 1) <= cmd_last);
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                count[c] <= `RCC_COUNT_RESET;
            end else if (cleared) begin
                count[c] <= `RCC_COUNT_RESET;
            end else if (closure) begin
                count[c] <= count[c] + COUNT_W'(1);
            end
        end
        assign nv_data[c*COUNT_W +: COUNT_W] = count[c];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            relay_prev <= '0;
        end else begin
            relay_prev <= relay_closed;
        end
    end

    // ------------------------------------------------------------
    // Calibration mode
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first_cycle        <= 1'b1;
            key_seen           <= 1'b0;
            calibration_active <= 1'b0;
        end else begin
            first_cycle <= 1'b0;
            if (first_cycle) begin
                key_seen <= front_key_at_powerup;
            end
            if (calibration_lock_request) begin
                calibration_active <= 1'b0;
            end else if (calibration_unlock_request && key_seen) begin
                calibration_active <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Interval and flush timer
    // ------------------------------------------------------------
    rcc_minute_tick #(
        .MINUTE_CYCLES (MINUTE_CYCLES)
    ) u_tick (
        .clock   (clock),
        .rst_n   (rst_n),
        .restart (nv_done),
        .tick    (tick)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            interval <= `RCC_INTERVAL_RESET;
            minutes  <= 11'h000;
        end else begin
            if (is_setint && int_ok) begin
                interval <= cmd_interval;
            end
            if (nv_done || expired) begin
                minutes <= 11'h000;
            end else if (tick && state == RCC_IDLE) begin
                minutes <= minutes + 11'h001;
            end
        end
    end

    assign next_state = (state == RCC_IDLE && flush_req) ? RCC_WRITE :
                        (state == RCC_WRITE)             ? RCC_WAIT  :
                        (nv_done)                        ? RCC_IDLE  : state;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state    <= RCC_IDLE;
            nv_write <= 1'b0;
        end else begin
            state    <= next_state;
            nv_write <= (next_state == RCC_WRITE);
        end
    end

    // ------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------
    // counts are read by the remote port and, through nv_data, by the store
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scan_busy <= 1'b0;
            scan_ch   <= 8'h00;
            scan_last <= 8'h00;
        end else if (query_go) begin
            scan_busy <= 1'b1;
            scan_ch   <= cmd_first;
            scan_last <= cmd_last;
        end else if (scan_busy) begin
            scan_ch   <= scan_ch + 8'h01;
            scan_busy <= (scan_ch != scan_last);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid  <= 1'b0;
            resp_data   <= '0;
            cmd_refused <= 1'b0;
        end else begin
            cmd_refused <= refuse;
            resp_valid  <= scan_idx_ok || is_rdint;
            resp_data   <= scan_idx_ok ? count[scan_idx[$clog2(CHANNELS)-1:0]] :
                           COUNT_W'(interval);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_single_count: assert property (@(posedge clock) disable iff (!rst_n)
        relay_closed[0] && relay_prev[0] && !clear_go
        |=> count[0] == $past(count[0]))
        else $error("count moved without open-to-closed transition");
    a_closure_inc: assert property (@(posedge clock) disable iff (!rst_n)
        relay_closed[0] && !relay_prev[0] && !clear_go
        |=> count[0] == $past(count[0]) + COUNT_W'(1))
        else $error("closure not counted");
    a_clear_locked: assert property (@(posedge clock) disable iff (!rst_n)
        is_clear && !calibration_active |=> cmd_refused)
        else $error("clear accepted while locked");
    a_clear_zero: assert property (@(posedge clock) disable iff (!rst_n)
        clear_go && cmd_first == 8'h01 |=> count[0] == '0)
        else $error("clear did not zero count");
    a_interval_range: assert property (@(posedge clock) disable iff (!rst_n)
        is_setint && !int_ok |=> interval == $past(interval))
        else $error("out of range interval accepted");
    a_interval_read: assert property (@(posedge clock) disable iff (!rst_n)
        is_rdint && !scan_busy |=> resp_valid && resp_data == COUNT_W'($past(interval)))
        else $error("interval readback wrong");
    a_flush_cause: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(nv_write) |-> $past(expired) || $past(query_go))
        else $error("flush without cause");
    a_query_flush: assert property (@(posedge clock) disable iff (!rst_n)
        query_go && state == RCC_IDLE |=> nv_write)
        else $error("query did not flush");
    a_timer_restart: assert property (@(posedge clock) disable iff (!rst_n)
        nv_done |=> minutes == 11'h000)
        else $error("timer not restarted after write");
    a_default_int: assert property (@(posedge clock)
        $rose(rst_n) |-> interval == `RCC_INTERVAL_RESET)
        else $error("interval default wrong");

    c_closure: cover property (@(posedge clock) disable iff (!rst_n)
        relay_closed[0] && !relay_prev[0]);
    c_query: cover property (@(posedge clock) disable iff (!rst_n) query_go ##[1:20] nv_done);
    c_clear: cover property (@(posedge clock) disable iff (!rst_n) clear_go);
    c_expiry: cover property (@(posedge clock) disable iff (!rst_n) expired);
endmodule

// ==== rcc_minute_tick.sv ====
// Purpose: one-cycle tick once per minute
// Assumes: asynchronous active-low reset with release already synchronised
// Notes:   period is a parameter so simulation can shorten it
`timescale 1ns/1ns
`include "rcc_regs.svh"
module rcc_minute_tick import rcc_pkg::*; #(
    parameter int unsigned MINUTE_CYCLES = `RCC_MINUTE_CYCLES
) (
    input  wire logic clock,    // System clock
    input  wire logic rst_n,    // Synchronised reset
    input  wire logic restart,  // Restart the minute
    output logic      tick      // One pulse per minute
);
    logic [31:0] count;
    wire         at_end = (count == 32'(MINUTE_CYCLES - 1));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else begin
            count <= (restart || at_end) ? 32'h0000_0000 : count + 32'h0000_0001;
            tick  <= at_end && !restart;
        end
    end
endmodule

// ==== rcc_nv_model.sv ====
// Purpose: nonvolatile store model facing the closure counter
// Assumes: one store write in flight at a time
// Notes:   ack delay is set by the bench; 0 answers on the next cycle
`timescale 1ns/1ns
module rcc_nv_model (
    input  wire logic         clock,     // System clock
    input  wire logic         nv_write,  // Write strobe
    input  wire logic [319:0] nv_data,   // Counts to store
    input  wire logic [7:0]   ack_delay, // Cycles before ack
    output logic              nv_ack,    // Write done pulse
    output logic [319:0]      stored,    // Last stored image
    output logic [15:0]       writes     // Writes seen
);
    logic       busy;
    logic [7:0] wait_cnt;

    initial begin
        nv_ack = 1'b0;
        busy = 1'b0;
        wait_cnt = 8'h00;
        writes = 16'h0000;
        stored = '0;
    end

    // Image taken with the strobe, since nv_data is a live copy
    always @(posedge clock) begin
        nv_ack <= 1'b0;
        if (nv_write === 1'b1) begin
            stored <= nv_data;
            writes <= writes + 16'h0001;
            busy <= 1'b1;
            wait_cnt <= ack_delay;
        end else if (busy && wait_cnt == 8'h00) begin
            nv_ack <= 1'b1;
            busy <= 1'b0;
        end else if (busy) begin
            wait_cnt <= wait_cnt - 8'h01;
        end
    end
endmodule

// ==== rcc_pkg.sv ====
// Purpose: types for the relay closure counter
// Assumes: nothing
// Notes:   constants live in rcc_regs.svh
package rcc_pkg;
    typedef enum logic [2:0] {
        RCC_IDLE  = 3'b000,
        RCC_WRITE = 3'b001,
        RCC_WAIT  = 3'b011
    } rcc_state_t;
    typedef enum logic [1:0] {
        RCC_CMD_QUERY    = 2'b00,
        RCC_CMD_CLEAR    = 2'b01,
        RCC_CMD_SET_INT  = 2'b10,
        RCC_CMD_READ_INT = 2'b11
    } rcc_cmd_t;
endpackage

// ==== rcc_regs.svh ====
// Purpose: constants for the relay closure counter
// Assumes: 25 MHz clock
// Notes:   definitions only
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH
`define RCC_CLOCK_HZ          25_000_000
`define RCC_MINUTE_S          60
`define RCC_MINUTE_CYCLES     (`RCC_CLOCK_HZ * `RCC_MINUTE_S)
`define RCC_INTERVAL_RESET    11'h00F
`define RCC_INTERVAL_MIN      11'h001
`define RCC_INTERVAL_MAX      11'h5A0
`define RCC_SLOT_DIGIT        4'h1
`define RCC_COUNT_RESET       32'h0000_0000
`endif

// ==== relay_closure_counter_bench.sv ====
// Purpose: self-checking bench for the relay closure counter
// Assumes: minute shortened to 10 cycles, key held at the first power-up
// Notes:   relays stay still while commands run, so clears never race closures
`timescale 1ns/1ns
module relay_closure_counter_bench;
    logic          clock, resetn, cmd_valid, unlock, lock, key, nv_ack;
    logic          resp_valid, cmd_refused, nv_write, cal_active;
    logic [9:0]    relay_closed, prev;
    logic [1:0]    cmd_code;
    logic [3:0]    cmd_slot;
    logic [7:0]    cmd_first, cmd_last, ack_delay;
    logic [10:0]   cmd_interval, iv;
    logic [31:0]   resp_data, seed, r, v;
    logic [319:0]  nv_data, stored;
    logic [15:0]   writes, w0;
    logic [31:0]   exp_cnt [10];
    logic [31:0]   q [$];
    int            errors, checks, refusals, r0;

    rcc_counter #(.MINUTE_CYCLES(10)) uut (
        .clock(clock), .resetn(resetn), .relay_closed(relay_closed), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_slot(cmd_slot), .cmd_first(cmd_first),
        .cmd_last(cmd_last), .cmd_interval(cmd_interval),
        .calibration_unlock_request(unlock), .calibration_lock_request(lock),
        .front_key_at_powerup(key), .nv_ack(nv_ack), .resp_valid(resp_valid),
        .resp_data(resp_data), .cmd_refused(cmd_refused), .nv_write(nv_write),
        .nv_data(nv_data), .calibration_active(cal_active));

    rcc_nv_model nv (.clock(clock), .nv_write(nv_write), .nv_data(nv_data),
        .ack_delay(ack_delay), .nv_ack(nv_ack), .stored(stored), .writes(writes));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Output pulses last one cycle, so every edge is looked at
    always @(posedge clock) begin
        if (resp_valid === 1'b1) q.push_back(resp_data);
        if (cmd_refused === 1'b1) refusals++;
    end

    task automatic cmd(input logic [1:0] c, input logic [3:0] s, input logic [7:0] f,
                       input logic [7:0] l, input logic [10:0] i);
        q.delete();
        r0 = refusals;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_slot <= s;
        cmd_first <= f;
        cmd_last <= l;
        cmd_interval <= i;
        @(posedge clock);
        cmd_valid <= 1'b0;
        repeat (16) @(posedge clock);
    endtask

    task automatic query(input int f, input int l);
        cmd(2'd0, 4'h1, 8'(f), 8'(l), 11'h000);
        chk(32'(q.size()), 32'(l - f + 1));
        foreach (q[i]) chk(q[i], exp_cnt[f - 1 + i]);
    endtask

    // Lock or unlock pulse, one cycle wide
    task automatic pulse(input bit lock_it);
        @(posedge clock);
        if (lock_it) lock <= 1'b1;
        else unlock <= 1'b1;
        @(posedge clock);
        lock <= 1'b0;
        unlock <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    initial begin
        #800000;
        errors++;
        final_report();
    end

    initial begin
        {resetn, cmd_valid, unlock, lock, cmd_code, cmd_slot} = '0;
        {cmd_first, cmd_last, cmd_interval, relay_closed, prev} = '0;
        {errors, checks, refusals} = '0;
        key = 1'b1;
        ack_delay = 8'h00;
        seed = 32'he102_f028;
        foreach (exp_cnt[c]) exp_cnt[c] = 32'h0000_0000;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        // ------------------------------------------------------------
        // Interval programming
        // ------------------------------------------------------------
        cmd(2'd3, 4'h1, 8'h01, 8'h01, 11'h000);
        chk(q.size() ? q[0] : 32'hFFFF_FFFF, 32'h0000_000F);
        cmd(2'd2, 4'h1, 8'h01, 8'h01, 11'h000);
        chk(refusals - r0, 1);
        cmd(2'd2, 4'h1, 8'h01, 8'h01, 11'h5A1);
        chk(refusals - r0, 1);
        iv = 11'(xs() % 1440 + 1);
        cmd(2'd2, 4'h1, 8'h01, 8'h01, iv);
        cmd(2'd3, 4'h1, 8'h01, 8'h01, 11'h000);
        chk(q.size() ? q[0] : 32'hFFFF_FFFF, {21'h0, iv});
        // Longest interval keeps timer flushes out of the query checks
        cmd(2'd2, 4'h1, 8'h01, 8'h01, 11'h5A0);
        chk(refusals - r0, 0);
        $display("interval test done");
        // ------------------------------------------------------------
        // Random closures, held closes, query and flush
        // ------------------------------------------------------------
        w0 = writes;
        repeat (300) begin
            @(posedge clock);
            r = xs();
            v = r[30] ? 32'(prev | r[9:0]) : 32'(prev & r[19:10]);
            relay_closed <= v[9:0];
            for (int c = 0; c < 10; c++) if (v[c] & ~prev[c]) exp_cnt[c]++;
            prev = v[9:0];
        end
        repeat (2) @(posedge clock);
        chk(32'(writes - w0), 0);
        query(1, 10);
        chk(32'(writes - w0), 1);
        for (int c = 0; c < 10; c++) chk(stored[32*c +: 32], exp_cnt[c]);
        query(4, 4);
        cmd(2'd0, 4'h2, 8'h01, 8'h02, 11'h000);
        chk(refusals - r0, 1);
        $display("closure test done");
        // ------------------------------------------------------------
        // Count clear under calibration lock
        // ------------------------------------------------------------
        cmd(2'd1, 4'h1, 8'h02, 8'h07, 11'h000);
        chk(refusals - r0, 1);
        pulse(1'b0);
        chk(32'(cal_active), 1);
        cmd(2'd1, 4'h1, 8'h02, 8'h07, 11'h000);
        chk(refusals - r0, 0);
        cmd(2'd1, 4'h1, 8'h01, 8'h01, 11'h000);
        chk(refusals - r0, 0);
        for (int c = 0; c < 7; c++) exp_cnt[c] = 32'h0000_0000;
        query(1, 10);
        pulse(1'b1);
        chk(32'(cal_active), 0);
        $display("clear test done");
        // ------------------------------------------------------------
        // Timer flush with a slow store
        // ------------------------------------------------------------
        ack_delay <= 8'h14;
        cmd(2'd2, 4'h1, 8'h01, 8'h01, 11'h001);
        w0 = writes;
        repeat (120) @(posedge clock);
        chk(32'(writes - w0 >= 16'h0002), 1);
        for (int c = 0; c < 10; c++) chk(stored[32*c +: 32], exp_cnt[c]);
        $display("timer test done");
        // ------------------------------------------------------------
        // Second reset without the key held
        // ------------------------------------------------------------
        key <= 1'b0;
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        pulse(1'b0);
        chk(32'(cal_active), 0);
        cmd(2'd3, 4'h1, 8'h01, 8'h01, 11'h000);
        chk(q.size() ? q[0] : 32'hFFFF_FFFF, 32'h0000_000F);
        $display("reset test done");
        final_report();
    end
endmodule
